// file: pkg/wim_defines.vh
`ifndef WIM_DEFINES_VH
`define WIM_DEFINES_VH

// ----------------------------------------
// Clock and filter timing
// ----------------------------------------
`define WIM_CLK_MHZ 125
`define WIM_SHORT_FILTER_US 16
`define WIM_LONG_FILTER_US 64
`define WIM_SHORT_FILTER_CYC (`WIM_SHORT_FILTER_US * `WIM_CLK_MHZ)
`define WIM_LONG_FILTER_CYC (`WIM_LONG_FILTER_US * `WIM_CLK_MHZ)
`define WIM_FILT_CW 14

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define WIM_MODE_NORMAL 3'h0
`define WIM_MODE_STOP 3'h1
`define WIM_MODE_SLEEP 3'h2
`define WIM_MODE_FAILSAFE 3'h3
`define WIM_MODE_RESTART 3'h4
`define WIM_MODE_INIT 3'h5

// ----------------------------------------
// Filter select codes
// ----------------------------------------
`define WIM_FLT_STATIC_SHORT 2'h0
`define WIM_FLT_STATIC_LONG 2'h1
`define WIM_FLT_CYCLIC_T1 2'h2
`define WIM_FLT_CYCLIC_T2 2'h3

// ----------------------------------------
// Pull select codes
// ----------------------------------------
`define WIM_PULL_NONE 2'h0
`define WIM_PULL_DOWN 2'h1
`define WIM_PULL_UP 2'h2
`define WIM_PULL_AUTO 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WIM_RST_WAKE_STATUS 3'h0
`define WIM_RST_ALT_STATUS 2'h0
`define WIM_RST_LEVEL 3'h0
`define WIM_RST_PULL 3'h0

`endif

// file: core/wim_filter.v
`timescale 1ns/1ps
`include "wim_defines.vh"

module wim_filter #(
    parameter integer SHORT_CYC = `WIM_SHORT_FILTER_CYC,
    parameter integer LONG_CYC = `WIM_LONG_FILTER_CYC,
    parameter integer CW = `WIM_FILT_CW
) (
    input wire clk_sys,
    input wire rstn,
    input wire clk_en,
    input wire pin_in,
    input wire active,
    input wire sel_long,
    input wire gate,
    output reg event_q,
    output reg level_q,
    output reg stable_q
);

    // ----------------------------------------
    // Synchroniser and filter state
    // ----------------------------------------
    reg sync1_q;
    reg sync2_q;
    reg prev_q;
    reg [CW-1:0] cnt_q;
    wire [CW-1:0] limit;

    assign limit = sel_long ? LONG_CYC[CW-1:0] : SHORT_CYC[CW-1:0];

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            event_q <= 1'b0;
            level_q <= 1'b0;
            stable_q <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            event_q <= 1'b0;
            if (active) begin
                prev_q <= sync2_q;
                level_q <= sync2_q;
            end
            if (!active || gate) begin
                cnt_q <= {CW{1'b0}};
            end else if (sync2_q != prev_q || sync2_q == stable_q) begin
                cnt_q <= {CW{1'b0}};
            end else if (cnt_q >= limit - 1'b1) begin
                cnt_q <= {CW{1'b0}};
                stable_q <= sync2_q;
                event_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule // wim_filter

// file: core/wim_top.v
`timescale 1ns/1ps
`include "wim_defines.vh"

module wim_top #(
    parameter integer NPIN = 3,
    parameter integer NFO = 2,
    parameter integer SHORT_CYC = `WIM_SHORT_FILTER_CYC,
    parameter integer LONG_CYC = `WIM_LONG_FILTER_CYC
) (
    input wire clk_sys,
    input wire rstn,
    input wire clk_en,
    input wire [2:0] op_mode,
    input wire [NPIN-1:0] wake_pin_in,
    input wire [NFO-1:0] fail_output_pins,
    input wire [NFO-1:0] fo_wake_config,
    input wire [NPIN-1:0] wake_enable_control,
    input wire [2*NPIN-1:0] filter_mode_control,
    input wire [2*NPIN-1:0] pull_current_control,
    input wire cyclic_timer_one_on,
    input wire cyclic_timer_two_on,
    input wire measure_enable,
    input wire [NPIN-1:0] wake_status_clear,
    input wire [NFO-1:0] alt_status_clear,
    input wire sleep_cmd,
    output reg [NPIN-1:0] wake_event_status_q,
    output reg [NFO-1:0] alt_wake_event_status_q,
    output reg [NPIN-1:0] pin_level_status_q,
    output reg [NPIN-1:0] pull_up_en_q,
    output reg [NPIN-1:0] pull_down_en_q,
    output reg measure_switch_q,
    output reg wake_irq_q,
    output reg wake_up_q,
    output reg cmd_fault_q,
    output reg restart_req_q,
    output reg sleep_go_q
);

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire mode_run;
    wire mode_low;
    wire meas_on;

    assign mode_run = (op_mode == `WIM_MODE_NORMAL) || (op_mode == `WIM_MODE_STOP);
    assign mode_low = (op_mode == `WIM_MODE_SLEEP) || (op_mode == `WIM_MODE_FAILSAFE);
    assign meas_on = measure_enable;

    // ----------------------------------------
    // Wake pin channels
    // ----------------------------------------
    wire [NPIN-1:0] pin_event;
    wire [NPIN-1:0] pin_level;
    wire [NPIN-1:0] pin_stable;
    wire [NPIN-1:0] pin_gate;
    wire [NPIN-1:0] pin_cyclic;
    wire [NPIN-1:0] pin_en_eff;
    wire [NPIN-1:0] pin_hit;
    wire [NPIN-1:0] pull_up_d;
    wire [NPIN-1:0] pull_down_d;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
            wire [1:0] fsel;
            wire [1:0] psel;
            wire act;
            wire lvl_now;

            assign fsel = filter_mode_control[2*gi+1:2*gi];
            assign psel = pull_current_control[2*gi+1:2*gi];
            assign pin_gate[gi] = meas_on && (gi < 2);
            assign pin_cyclic[gi] = fsel[1];
            // Sensing window per filter selection
            assign act = (fsel == `WIM_FLT_CYCLIC_T1) ? cyclic_timer_one_on :
                         (fsel == `WIM_FLT_CYCLIC_T2) ? cyclic_timer_two_on :
                         1'b1;
            assign pin_en_eff[gi] = wake_enable_control[gi] && !pin_gate[gi];
            assign pin_hit[gi] = pin_event[gi] && pin_en_eff[gi];
            assign lvl_now = pin_level[gi];
            // Pull current selection, auto follows level
            assign pull_up_d[gi] = !pin_gate[gi] &&
                ((psel == `WIM_PULL_UP) ||
                 ((psel == `WIM_PULL_AUTO) && lvl_now));
            assign pull_down_d[gi] = !pin_gate[gi] &&
                ((psel == `WIM_PULL_DOWN) ||
                 ((psel == `WIM_PULL_AUTO) && !lvl_now));

            wim_filter #(
                .SHORT_CYC(SHORT_CYC),
                .LONG_CYC(LONG_CYC),
                .CW(`WIM_FILT_CW)
            ) u_filt (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .clk_en(clk_en),
                .pin_in(wake_pin_in[gi]),
                .active(act),
                .sel_long(fsel == `WIM_FLT_STATIC_LONG),
                .gate(pin_gate[gi]),
                .event_q(pin_event[gi]),
                .level_q(pin_level[gi]),
                .stable_q(pin_stable[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Fail-output pins used as wake inputs
    // ----------------------------------------
    wire [NFO-1:0] fo_event;
    wire [NFO-1:0] fo_hit;

    genvar gf;
    generate
        for (gf = 0; gf < NFO; gf = gf + 1) begin : g_fo
            assign fo_hit[gf] = fo_event[gf] && fo_wake_config[gf];

            wim_filter #(
                .SHORT_CYC(SHORT_CYC),
                .LONG_CYC(LONG_CYC),
                .CW(`WIM_FILT_CW)
            ) u_filt (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .clk_en(clk_en),
                .pin_in(fail_output_pins[gf]),
                .active(1'b1),
                .sel_long(1'b0),
                .gate(!fo_wake_config[gf]),
                .event_q(fo_event[gf]),
                .level_q(),
                .stable_q()
            );
        end
    endgenerate

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    wire [NPIN-1:0] wake_status_d;
    wire [NFO-1:0] alt_status_d;
    wire [NPIN-1:0] level_d;
    wire [NPIN-1:0] level_upd;
    wire any_hit;

    // Set wins over a clear in the same cycle
    assign wake_status_d = (wake_event_status_q & ~wake_status_clear) | pin_hit;
    assign alt_status_d = (alt_wake_event_status_q & ~alt_status_clear) | fo_hit;
    // Level follows the filter sample even if the pin is not a wake source
    assign level_upd = {NPIN{mode_run}} & ~pin_gate;
    assign level_d = (level_upd & pin_level) | (~level_upd & pin_level_status_q);
    assign any_hit = (|pin_hit) || (|fo_hit);

    // ----------------------------------------
    // Sleep command check
    // ----------------------------------------
    wire only_meas_src;

    assign only_meas_src = meas_on && (|wake_enable_control[1:0]) &&
        !(|wake_enable_control[NPIN-1:2]) && !(|fo_wake_config);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wake_event_status_q <= `WIM_RST_WAKE_STATUS;
            alt_wake_event_status_q <= `WIM_RST_ALT_STATUS;
            pin_level_status_q <= `WIM_RST_LEVEL;
            pull_up_en_q <= `WIM_RST_PULL;
            pull_down_en_q <= `WIM_RST_PULL;
            measure_switch_q <= 1'b0;
            wake_irq_q <= 1'b0;
            wake_up_q <= 1'b0;
            cmd_fault_q <= 1'b0;
            restart_req_q <= 1'b0;
            sleep_go_q <= 1'b0;
        end else if (clk_en) begin
            wake_event_status_q <= wake_status_d;
            alt_wake_event_status_q <= alt_status_d;
            pin_level_status_q <= level_d;
            pull_up_en_q <= pull_up_d;
            pull_down_en_q <= pull_down_d;
            measure_switch_q <= meas_on && (op_mode == `WIM_MODE_NORMAL);
            wake_irq_q <= any_hit && mode_run;
            wake_up_q <= any_hit && mode_low;
            restart_req_q <= sleep_cmd && only_meas_src;
            sleep_go_q <= sleep_cmd && !only_meas_src;
            if (sleep_cmd && only_meas_src) begin
                cmd_fault_q <= 1'b1;
            end
        end
    end

endmodule // wim_top

// file: bench/wim_top_properties.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module wim_top_properties (
    input wire clk_sys,
    input wire rstn,
    input wire [2:0] op_mode,
    input wire measure_enable,
    input wire sleep_cmd,
    input wire [1:0] fo_wake_config,
    input wire [2:0] wake_enable_control,
    input wire [5:0] pull_current_control,
    input wire [2:0] wake_status_clear,
    input wire [2:0] wake_event_status_q,
    input wire [1:0] alt_wake_event_status_q,
    input wire [2:0] pull_up_en_q,
    input wire [2:0] pull_down_en_q,
    input wire measure_switch_q,
    input wire wake_irq_q,
    input wire wake_up_q,
    input wire restart_req_q,
    input wire sleep_go_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_switch_normal: assert property (
        measure_switch_q == $past(measure_enable && op_mode == 3'h0)) else $error("switch");
    a_irq_mode: assert property (
        wake_irq_q |-> $past(op_mode) == 3'h0 || $past(op_mode) == 3'h1) else $error("irq mode");
    a_wake_mode: assert property (
        wake_up_q |-> $past(op_mode) == 3'h2 || $past(op_mode) == 3'h3) else $error("wake mode");
    a_irq_flag: assert property (
        wake_irq_q |-> (|wake_event_status_q) || (|alt_wake_event_status_q)) else $error("irq");
    a_meas_pulls: assert property (
        measure_enable [*2] |-> (pull_up_en_q[1:0] | pull_down_en_q[1:0]) == 2'h0)
        else $error("pulls");
    a_meas_flags: assert property (
        measure_enable [*4] |-> !$rose(wake_event_status_q[0]) && !$rose(wake_event_status_q[1]))
        else $error("flags");
    a_pull_decode: assert property (
        $stable(pull_current_control[5:4]) && pull_current_control[5:4] != 2'h3
        |-> {pull_up_en_q[2], pull_down_en_q[2]} == pull_current_control[5:4]) else $error("pull");
    a_sleep_refuse: assert property (
        sleep_cmd && measure_enable && wake_enable_control == 3'h3 && fo_wake_config == 2'h0
        |=> restart_req_q && !sleep_go_q) else $error("sleep");
    a_flag_sticky: assert property (
        $fell(wake_event_status_q[2]) |-> $past(wake_status_clear[2])) else $error("sticky");
endmodule // wim_top_properties
bind wim_top wim_top_properties i_wim_top_properties (.*);

// file: bench/wim_pins.sv
`timescale 1ns/1ps
// ----
// Wake switches with pull currents
// ----
module wim_pins (
    input wire clk_sys,
    input wire [2:0] sw_on,
    input wire [2:0] sw_lvl,
    input wire [2:0] pull_up_en_q,
    input wire [2:0] pull_down_en_q,
    output wire [2:0] wake_pin_in
);
    reg flt_q = 1'b0;
    always @(posedge clk_sys) begin
        flt_q <= !flt_q;
    end
    // Open switch: pulls decide, else the pin wanders
    assign wake_pin_in = (sw_on & sw_lvl) |
        (~sw_on & (pull_up_en_q | (~pull_down_en_q & {3{flt_q}})));
endmodule // wim_pins

// file: bench/wim_top_tb.sv
`timescale 1ns/1ps
module wim_top_tb;
    localparam integer SC = 4;
    localparam integer LC = 8;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg clk_en = 1'b1;
    reg [2:0] op_mode = 3'h0;
    reg [1:0] fail_output_pins = 2'h0;
    reg [1:0] fo_wake_config = 2'h0;
    reg [2:0] wake_enable_control = 3'h7;
    reg [5:0] filter_mode_control = 6'h00;
    reg [5:0] pull_current_control = 6'h00;
    reg cyclic_timer_one_on = 1'b0;
    reg cyclic_timer_two_on = 1'b0;
    reg measure_enable = 1'b0;
    reg [2:0] wake_status_clear = 3'h0;
    reg [1:0] alt_status_clear = 2'h0;
    reg sleep_cmd = 1'b0;
    reg [2:0] sw_on = 3'h7;
    reg [2:0] sw_lvl = 3'h0;
    wire [2:0] wake_pin_in, wake_event_status_q, pin_level_status_q, pull_up_en_q, pull_down_en_q;
    wire [1:0] alt_wake_event_status_q;
    wire measure_switch_q, wake_irq_q, wake_up_q, cmd_fault_q, restart_req_q, sleep_go_q;
    integer n_errors = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer i;
    wim_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_wim_top (.*);
    wim_pins i_wim_pins (.*);
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // ----
    // Helpers
    // ----
    task final_report;
        begin
            $display("tests %0d errors %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task tk(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Toggle pin p; e is the flag delay in cycles, 0 for none; iw is {wake, irq}
    task evt(input integer p, input integer e, input [1:0] iw);
        integer n;
        begin
            @(posedge clk_sys);
            sw_lvl[p] <= !sw_lvl[p];
            n = 0;
            while (wake_event_status_q[p] !== 1'b1 && n < 40) begin
                @(posedge clk_sys);
                #1;
                n = n + 1;
            end
            chk("delay", e, (n < 40) ? n : 0);
            chk("pulse", iw, {wake_up_q, wake_irq_q});
            chk("flags", (e > 0) ? (1 << p) : 0, wake_event_status_q);
            @(posedge clk_sys);
            wake_status_clear <= 3'h7;
            alt_status_clear <= 2'h3;
            @(posedge clk_sys);
            wake_status_clear <= 3'h0;
            alt_status_clear <= 2'h0;
        end
    endtask
    // ----
    // Scenarios
    // ----
    task s_filter;
        begin
            evt(2, SC + 4, 2'h1);
            evt(2, SC + 4, 2'h1);
            filter_mode_control <= 6'h10;
            evt(2, LC + 4, 2'h1);
            @(posedge clk_sys);
            sw_lvl[2] <= !sw_lvl[2];
            tk(2);
            evt(2, 0, 2'h0);
        end
    endtask
    task s_cyclic;
        for (i = 2; i < 4; i = i + 1) begin
            @(posedge clk_sys);
            filter_mode_control <= {i[1:0], 4'h0};
            evt(2, 0, 2'h0);
            evt(2, 0, 2'h0);
            cyclic_timer_one_on <= (i == 2);
            cyclic_timer_two_on <= (i == 3);
            evt(2, SC + 4, 2'h1);
            cyclic_timer_one_on <= 1'b0;
            cyclic_timer_two_on <= 1'b0;
            filter_mode_control <= 6'h00;
        end
    endtask
    task s_level;
        begin
            wake_enable_control <= 3'h3;
            evt(2, 0, 2'h0);
            tk(4);
            chk("level", sw_lvl, pin_level_status_q);
            wake_enable_control <= 3'h7;
        end
    endtask
    task s_modes;
        for (i = 1; i < 4; i = i + 1) begin
            op_mode <= i[2:0];
            evt(2, SC + 4, (i == 1) ? 2'h1 : 2'h2);
            op_mode <= 3'h0;
            tk(1);
        end
    endtask
    task s_alt;
        begin
            fo_wake_config <= 2'h1;
            tk(2);
            fail_output_pins <= 2'h1;
            tk(SC + 3);
            #1;
            chk("alt", 2'h0, alt_wake_event_status_q);
            tk(1);
            #1;
            chk("alt", 2'h1, alt_wake_event_status_q);
            tk(1);
            fo_wake_config <= 2'h0;
        end
    endtask
    task s_pull;
        begin
            sw_on[2] <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                pull_current_control <= {i[1:0], 4'h0};
                tk(3);
                #1;
                chk("pull", i, {pull_up_en_q[2], pull_down_en_q[2]});
            end
            sw_on[2] <= 1'b1;
            pull_current_control <= 6'h30;
            for (i = 0; i < 2; i = i + 1) begin
                sw_lvl[2] <= i[0];
                tk(8);
                #1;
                chk("auto", i + 1, {pull_up_en_q[2], pull_down_en_q[2]});
            end
            pull_current_control <= 6'h00;
            tk(1);
            wake_status_clear <= 3'h7;
            tk(1);
            wake_status_clear <= 3'h0;
            evt(2, SC + 4, 2'h1);
        end
    endtask
    task s_meas;
        begin
            measure_enable <= 1'b1;
            pull_current_control <= 6'h0a;
            tk(3);
            #1;
            chk("switch", 1, measure_switch_q);
            chk("pulls", 0, {pull_up_en_q[1:0], pull_down_en_q[1:0]});
            evt(0, 0, 2'h0);
            chk("level", 0, pin_level_status_q[0]);
            op_mode <= 3'h1;
            tk(3);
            #1;
            chk("switch", 0, measure_switch_q);
        end
    endtask
    task s_sleep;
        for (i = 0; i < 2; i = i + 1) begin
            op_mode <= 3'h0;
            wake_enable_control <= (i == 0) ? 3'h3 : 3'h7;
            tk(1);
            sleep_cmd <= 1'b1;
            tk(1);
            sleep_cmd <= 1'b0;
            #1;
            chk("sleep", (i == 0) ? 3'h6 : 3'h3, {restart_req_q, cmd_fault_q, sleep_go_q});
            tk(1);
            measure_enable <= (i == 0);
        end
    endtask
    initial begin
        tk(16);
        rstn <= 1'b1;
        tk(4);
        #1;
        chk("switch", 0, measure_switch_q);
        s_filter;
        s_cyclic;
        s_level;
        s_modes;
        s_alt;
        s_pull;
        s_meas;
        s_sleep;
        measure_enable <= 1'b0;
        tk(3);
        #1;
        chk("stored", 2'h3, pull_up_en_q[1:0]);
        final_report;
    end
endmodule // wim_top_tb
